// ==== core/wmr_regs.v ====
// APB register bank of the phase and capacitance wake-up measurements
`timescale 1ns/1ps
`include "wmr_defs.vh"

module wmr_regs #(
	parameter [4:0] DEVICE_TYPE_CODE      = 5'h1E,	// Arbitrary value
	parameter [2:0] SILICON_REVISION_CODE = 3'h7,	// Arbitrary value
	parameter       NUM_CHANNELS          = 2
) (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        ce,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        phaseResultValid,
	input  wire [7:0]  phaseResultIn,
	input  wire        capResultValid,
	input  wire [7:0]  capResultIn,
	output reg         wakeIrq
);

	// Bus decode
	wire [9:0]  regIdx;
	wire        setupPhase;
	wire        writeTaken;
	wire        hitEnable;
	wire        hitClear;
	wire        hitCommand;
	wire        clearWrite;
	wire        enableWrite;
	wire        setDefault;
	wire        refused;

	// Measurement inputs packed per channel
	wire [1:0]  measValid;
	wire [15:0] measData;

	// Register views gathered from the channels, plus identity and pending interrupt
	wire [15:0] cfgBus;
	wire [15:0] refBus;
	wire [15:0] avgBus;
	wire [15:0] resBus;
	wire [1:0]  tripBus;
	wire [7:0]  identity;
	wire        irqPending;

	// Interrupt state and bus answer
	reg  [1:0]  irqStatus_ff;
	reg  [1:0]  irqEnable_ff;
	reg  [1:0]  nxt_irqStatus;
	reg  [1:0]  nxt_irqEnable;
	reg  [31:0] rdMux;
	reg         mapped;
	reg         nxt_pready;
	reg         nxt_pslverr;
	reg  [31:0] nxt_prdata;

	assign regIdx      = paddr[11:2];
	assign setupPhase  = psel & ~penable;
	assign writeTaken  = psel & penable & pwrite & pready & ~pslverr;
	assign hitEnable   = (regIdx == `WMR_IDX_IRQ_ENABLE);
	assign hitClear    = (regIdx == `WMR_IDX_IRQ_CLEAR);
	assign hitCommand  = (regIdx == `WMR_IDX_COMMAND);
	assign clearWrite  = writeTaken & hitClear;
	assign enableWrite = writeTaken & hitEnable;
	assign setDefault  = writeTaken & hitCommand & pwdata[`WMR_CMD_SET_DEFAULT];
	assign measValid   = {capResultValid, phaseResultValid};
	assign measData    = {capResultIn, phaseResultIn};
	assign identity    = {DEVICE_TYPE_CODE, SILICON_REVISION_CODE};
	assign irqPending  = |(nxt_irqStatus & nxt_irqEnable);

	// One register group per measurement channel: config, reference, average, result
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHANNELS; gi = gi + 1) begin : gChan
			localparam integer BASE_I = `WMR_IDX_PHASE_CONFIG + `WMR_CHAN_STRIDE * gi;
			localparam [9:0]   BASE   = BASE_I[9:0];

			reg  [7:0]        config_ff;
			reg  [7:0]        reference_ff;
			reg  [7:0]        average_ff;
			reg  [7:0]        result_ff;
			wire              cfgWrite;
			wire              refWrite;
			wire              take;
			wire [3:0]        deltaField;
			wire              irqInAvg;
			wire [1:0]        weightCode;
			wire              useAvg;
			wire              above;
			wire [7:0]        upDiff;
			wire [7:0]        downDiff;
			wire [7:0]        newResult;
			wire [7:0]        cmpRef;
			wire [7:0]        absDiff;
			wire              trip;
			wire              enterAvg;
			wire [2:0]        shiftAmt;
			wire signed [9:0] step;
			wire signed [9:0] scaledStep;
			wire [9:0]        avgSum;

			assign cfgWrite   = writeTaken & (regIdx == BASE + `WMR_SUB_CONFIG);
			assign refWrite   = writeTaken & (regIdx == BASE + `WMR_SUB_REFERENCE);
			assign take       = measValid[gi];
			assign deltaField = config_ff[`WMR_CFG_DELTA_HI:`WMR_CFG_DELTA_LO];
			assign irqInAvg   = config_ff[`WMR_CFG_IRQ_IN_AVG];
			assign weightCode = config_ff[`WMR_CFG_WEIGHT_HI:`WMR_CFG_WEIGHT_LO];
			assign useAvg     = config_ff[`WMR_CFG_USE_AVG];
			assign newResult  = measData[gi*8 +: 8];
			assign cmpRef     = useAvg ? average_ff : reference_ff;
			assign above      = (newResult >= cmpRef);
			assign upDiff     = newResult - cmpRef;
			assign downDiff   = cmpRef - newResult;
			assign absDiff    = above ? upDiff : downDiff;
			assign trip       = absDiff > {4'h0, deltaField};
			assign enterAvg   = ~trip | irqInAvg;
			assign shiftAmt   = {1'b0, weightCode} + `WMR_WEIGHT_SHIFT_BASE;
			assign step       = $signed({2'b00, newResult}) - $signed({2'b00, average_ff});
			assign scaledStep = step >>> shiftAmt;
			assign avgSum     = {2'b00, average_ff} + scaledStep;

			// Configuration: written by software, cleared by the set-default command
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					config_ff <= `WMR_RST_BYTE;
				end else if (ce) begin
					if (setDefault) begin
						config_ff <= `WMR_RST_BYTE;
					end else if (cfgWrite) begin
						config_ff <= pwdata[7:0];
					end
				end
			end

			// Software reference used while averaging is not selected
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					reference_ff <= `WMR_RST_BYTE;
				end else if (ce) begin
					if (setDefault) begin
						reference_ff <= `WMR_RST_BYTE;
					end else if (refWrite) begin
						reference_ff <= pwdata[7:0];
					end
				end
			end

			// Latest result, shown until the next measurement or the set-default command
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					result_ff <= `WMR_RST_BYTE;
				end else if (ce) begin
					if (setDefault) begin
						result_ff <= `WMR_RST_BYTE;
					end else if (take) begin
						result_ff <= newResult;
					end
				end
			end

			// Running average; a tripping result enters only when allowed
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					average_ff <= `WMR_RST_BYTE;
				end else if (ce) begin
					if (setDefault) begin
						average_ff <= `WMR_RST_BYTE;
					end else if (take && enterAvg) begin
						average_ff <= avgSum[7:0];
					end
				end
			end

			assign cfgBus[gi*8 +: 8] = config_ff;
			assign refBus[gi*8 +: 8] = reference_ff;
			assign avgBus[gi*8 +: 8] = average_ff;
			assign resBus[gi*8 +: 8] = result_ff;
			assign tripBus[gi]       = measValid[gi] & trip;
		end
	endgenerate

	// Sticky status: a trip in the same cycle as its clear keeps the bit set
	always @* begin
		nxt_irqStatus = irqStatus_ff;
		if (clearWrite) begin
			nxt_irqStatus = irqStatus_ff & ~pwdata[1:0];
		end
		nxt_irqStatus = nxt_irqStatus | tripBus;
	end

	// Interrupt enable, plain read-write
	always @* begin
		nxt_irqEnable = irqEnable_ff;
		if (enableWrite) begin
			nxt_irqEnable = pwdata[1:0];
		end
	end

	// Read decode, sampled in the setup cycle
	always @* begin
		rdMux = 32'h0000_0000;
		case (regIdx)
			`WMR_IDX_PHASE_CONFIG:    rdMux[7:0] = cfgBus[7:0];
			`WMR_IDX_PHASE_REFERENCE: rdMux[7:0] = refBus[7:0];
			`WMR_IDX_PHASE_AVERAGE:   rdMux[7:0] = avgBus[7:0];
			`WMR_IDX_PHASE_RESULT:    rdMux[7:0] = resBus[7:0];
			`WMR_IDX_CAP_CONFIG:      rdMux[7:0] = cfgBus[15:8];
			`WMR_IDX_CAP_REFERENCE:   rdMux[7:0] = refBus[15:8];
			`WMR_IDX_CAP_AVERAGE:     rdMux[7:0] = avgBus[15:8];
			`WMR_IDX_CAP_RESULT:      rdMux[7:0] = resBus[15:8];
			`WMR_IDX_CHIP_IDENTITY:   rdMux[7:0] = identity;
			`WMR_IDX_IRQ_STATUS:      rdMux[1:0] = irqStatus_ff;
			`WMR_IDX_IRQ_ENABLE:      rdMux[1:0] = irqEnable_ff;
			`WMR_IDX_IRQ_CLEAR:       rdMux      = 32'h0000_0000;
			`WMR_IDX_COMMAND:         rdMux      = 32'h0000_0000;
			default:                  rdMux      = 32'h0000_0000;
		endcase
	end

	// Index map: anything outside it answers with an error
	always @* begin
		case (regIdx)
			`WMR_IDX_PHASE_CONFIG:    mapped = 1'b1;
			`WMR_IDX_PHASE_REFERENCE: mapped = 1'b1;
			`WMR_IDX_PHASE_AVERAGE:   mapped = 1'b1;
			`WMR_IDX_PHASE_RESULT:    mapped = 1'b1;
			`WMR_IDX_CAP_CONFIG:      mapped = 1'b1;
			`WMR_IDX_CAP_REFERENCE:   mapped = 1'b1;
			`WMR_IDX_CAP_AVERAGE:     mapped = 1'b1;
			`WMR_IDX_CAP_RESULT:      mapped = 1'b1;
			`WMR_IDX_CHIP_IDENTITY:   mapped = 1'b1;
			`WMR_IDX_IRQ_STATUS:      mapped = 1'b1;
			`WMR_IDX_IRQ_ENABLE:      mapped = 1'b1;
			`WMR_IDX_IRQ_CLEAR:       mapped = 1'b1;
			`WMR_IDX_COMMAND:         mapped = 1'b1;
			default:                  mapped = 1'b0;
		endcase
	end

	// Read-only registers refuse writes with an error
	function isReadOnly;
		input [9:0] idx;
		begin
			case (idx)
				`WMR_IDX_PHASE_AVERAGE: isReadOnly = 1'b1;
				`WMR_IDX_PHASE_RESULT:  isReadOnly = 1'b1;
				`WMR_IDX_CAP_AVERAGE:   isReadOnly = 1'b1;
				`WMR_IDX_CAP_RESULT:    isReadOnly = 1'b1;
				`WMR_IDX_CHIP_IDENTITY: isReadOnly = 1'b1;
				`WMR_IDX_IRQ_STATUS:    isReadOnly = 1'b1;
				default:                isReadOnly = 1'b0;
			endcase
		end
	endfunction

	assign refused = ~mapped | (pwrite & isReadOnly(regIdx));

	// Next bus answer: zero wait states, one-cycle pulse in the access cycle
	always @* begin
		nxt_pready  = 1'b0;
		nxt_pslverr = 1'b0;
		nxt_prdata  = 32'h0000_0000;
		if (setupPhase) begin
			nxt_pready  = 1'b1;
			nxt_pslverr = refused;
			if (!pwrite) begin
				nxt_prdata = rdMux;
			end
		end
	end

	// Sticky status bits
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irqStatus_ff <= `WMR_RST_STATUS;
		end else if (ce) begin
			irqStatus_ff <= nxt_irqStatus;
		end
	end

	// Enable bits
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irqEnable_ff <= `WMR_RST_STATUS;
		end else if (ce) begin
			irqEnable_ff <= nxt_irqEnable;
		end
	end

	// Output follows next-state so it rises together with its status bit
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wakeIrq <= 1'b0;
		end else if (ce) begin
			wakeIrq <= irqPending;
		end
	end

	// Bus answer flops; a low clock enable stalls the answer
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
		end else if (ce) begin
			pready <= nxt_pready;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pslverr <= 1'b0;
		end else if (ce) begin
			pslverr <= nxt_pslverr;
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			prdata <= nxt_prdata;
		end
	end

endmodule // wmr_regs

// ==== core/wmr_defs.vh ====
// Register indices, field positions, reset values and command codes of the wake-up register bank
`ifndef WMR_DEFS_VH
`define WMR_DEFS_VH

// Register indices; byte address is four times the index
`define WMR_IDX_PHASE_CONFIG     10'h036
`define WMR_IDX_PHASE_REFERENCE  10'h037
`define WMR_IDX_PHASE_AVERAGE    10'h038
`define WMR_IDX_PHASE_RESULT     10'h039
`define WMR_IDX_CAP_CONFIG       10'h03A
`define WMR_IDX_CAP_REFERENCE    10'h03B
`define WMR_IDX_CAP_AVERAGE      10'h03C
`define WMR_IDX_CAP_RESULT       10'h03D
`define WMR_IDX_CHIP_IDENTITY    10'h03F
`define WMR_IDX_IRQ_STATUS       10'h040
`define WMR_IDX_IRQ_ENABLE       10'h041
`define WMR_IDX_IRQ_CLEAR        10'h042
`define WMR_IDX_COMMAND          10'h043

// Spacing of the per-channel register groups, in indices
`define WMR_CHAN_STRIDE          10'h004
// Offsets inside a channel group
`define WMR_SUB_CONFIG           10'h000
`define WMR_SUB_REFERENCE        10'h001
`define WMR_SUB_AVERAGE          10'h002
`define WMR_SUB_RESULT           10'h003

// Configuration register fields
`define WMR_CFG_DELTA_HI         7
`define WMR_CFG_DELTA_LO         4
`define WMR_CFG_IRQ_IN_AVG       3
`define WMR_CFG_WEIGHT_HI        2
`define WMR_CFG_WEIGHT_LO        1
`define WMR_CFG_USE_AVG          0

// Weight code 00 means 4, so the shift is the code plus two
`define WMR_WEIGHT_SHIFT_BASE    3'h2

// Identity register fields
`define WMR_ID_TYPE_HI           7
`define WMR_ID_TYPE_LO           3
`define WMR_ID_REV_HI            2
`define WMR_ID_REV_LO            0

// Reset and default values
`define WMR_RST_BYTE             8'h00
`define WMR_RST_STATUS           2'h0

// Command register: writing this bit restores the channel register defaults; interrupt status and enable keep their values
`define WMR_CMD_SET_DEFAULT      0

// Interrupt bits, one per channel
`define WMR_CHAN_PHASE           0
`define WMR_CHAN_CAP             1

`endif

// ==== verification/wmr_regs_sva.sv ====
// Port assertions of the wake-up register bank
`timescale 1ns/1ps
module wmr_regs_sva #(
	parameter [4:0] DEVICE_TYPE_CODE      = 5'h1E,
	parameter [2:0] SILICON_REVISION_CODE = 3'h7,
	parameter       NUM_CHANNELS          = 2
) (
	input wire        clk_sys, rst_n, ce, psel, penable, pwrite, pready, pslverr, wakeIrq,
	input wire [11:0] paddr,
	input wire [31:0] pwdata, prdata,
	input wire        phaseResultValid, capResultValid,
	input wire [7:0]  phaseResultIn, capResultIn
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire       setup = psel && !penable && ce;
	wire [9:0] idx   = paddr[11:2];
	wire       acc   = psel && penable && pready && pwrite && !pslverr;
	// Last result per channel, cleared by the set-default command
	reg  [7:0] capSeen_ff, phaseSeen_ff;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			capSeen_ff <= 8'h00;
			phaseSeen_ff <= 8'h00;
		end else if (ce) begin
			capSeen_ff <= (acc && idx == 10'h043 && pwdata[0]) ? 8'h00 :
				capResultValid ? capResultIn : capSeen_ff;
			phaseSeen_ff <= (acc && idx == 10'h043 && pwdata[0]) ? 8'h00 :
				phaseResultValid ? phaseResultIn : phaseSeen_ff;
		end
	end
	a_ready_pulse: assert property (setup |=> pready ##1 !pready)
		else $error("ready not a one-cycle answer");
	a_ro_refused: assert property (setup && pwrite && (idx == 10'h038 || idx == 10'h039 ||
		idx == 10'h03C || idx == 10'h03D || idx == 10'h03F) |=> pready && pslverr)
		else $error("write to read-only register accepted");
	a_id_value: assert property (setup && !pwrite && idx == 10'h03F |=>
		prdata == {24'h000000, DEVICE_TYPE_CODE, SILICON_REVISION_CODE})
		else $error("identity value wrong");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_cap_view: assert property (setup && !pwrite && idx == 10'h03D |=>
		prdata[7:0] == $past(capSeen_ff)) else $error("capacitance result view wrong");
	a_phase_view: assert property (setup && !pwrite && idx == 10'h039 |=>
		prdata[7:0] == $past(phaseSeen_ff)) else $error("phase result view wrong");
	a_idle_quiet: assert property (!psel |=> !pready && prdata == 32'h00000000)
		else $error("answer without request");
	a_unmapped_err: assert property (setup && idx == 10'h03E |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_irq_clear: assert property (acc && idx == 10'h042 && pwdata[1:0] == 2'h3 &&
		!phaseResultValid && !capResultValid |=> !wakeIrq) else $error("interrupt not cleared");
endmodule // wmr_regs_sva

// ==== verification/wmr_meas_src.sv ====
// Measurement engine model delivering one result pulse per call
`timescale 1ns/1ps
module wmr_meas_src (
	input  wire       clk_sys,
	output reg        valid,
	output reg  [7:0] data
);
	initial begin
		valid = 1'b0;
		data = 8'h00;
	end
	task send(input [7:0] d);
		begin
			@(posedge clk_sys);
			valid <= 1'b1;
			data <= d;
			@(posedge clk_sys);
			valid <= 1'b0;
			// Released data does not keep the last value
			data <= ~d;
		end
	endtask
endmodule // wmr_meas_src

// ==== verification/wakeup_measure_regs_tb.sv ====
// Self-checking bench of the wake-up register bank
`timescale 1ns/1ps
module wakeup_measure_regs_tb;
	reg         clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, e, ceIn = 1;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0, r;
	wire [31:0] prdata;
	wire        pready, pslverr, wakeIrq, pV, cV;
	wire [7:0]  pD, cD;
	integer     n_fail = 0, tests_run = 0, j;
	always #10 clk_sys = ~clk_sys;
	wmr_regs DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ceIn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phaseResultValid(pV), .phaseResultIn(pD), .capResultValid(cV),
		.capResultIn(cD), .wakeIrq(wakeIrq));
	wmr_meas_src PHS (.clk_sys(clk_sys), .valid(pV), .data(pD));
	wmr_meas_src CAP (.clk_sys(clk_sys), .valid(cV), .data(cD));
	task stop_test;
		begin
			if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
			else $display("== FAILED ==");
			$finish;
		end
	endtask
	task chk(input [47:0] nm, input [31:0] x, input [31:0] g);
		begin
			tests_run = tests_run + 1;
			if (g !== x) begin
				n_fail = n_fail + 1;
				$display("BAD %0s expected %h seen %h", nm, x, g);
			end
		end
	endtask
	task apb(input w, input [9:0] i, input [7:0] d);
		begin
			@(posedge clk_sys);
			psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= {24'h0, d};
			@(posedge clk_sys);
			penable <= 1'b1;
			do begin @(posedge clk_sys); end while (pready !== 1'b1);
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rd(input [9:0] i, input [31:0] x); begin apb(1'b0, i, 8'h00); chk("rdata", x, r); end
	endtask
	task wr(input [9:0] i, input [7:0] d, input x); begin apb(1'b1, i, d); chk("slverr", {31'h0, x},
		{31'h0, e}); end endtask
	task irq(input x); begin @(posedge clk_sys); chk("irq", {31'h0, x}, {31'h0, wakeIrq}); end
	endtask
	task zeros; for (j = 8'h36; j < 8'h3E; j = j + 1) rd(j[9:0], 32'h0); endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		zeros;
		rd(10'h03F, 32'hF7);
		wr(10'h037, 8'h5A, 1'b0); rd(10'h037, 32'h5A);
		wr(10'h03B, 8'hC3, 1'b0); rd(10'h03B, 32'hC3);
		wr(10'h036, 8'hA5, 1'b0); rd(10'h036, 32'hA5);
		for (j = 8'h38; j < 8'h40; j = j + 1) if (j != 8'h3A && j != 8'h3B && j != 8'h3E) begin
			wr(j[9:0], 8'hFF, 1'b1); rd(j[9:0], j == 8'h3F ? 32'hF7 : 32'h0); end
		wr(10'h03E, 8'h11, 1'b1); rd(10'h03E, 32'h0);
		wr(10'h041, 8'h03, 1'b0); wr(10'h03B, 8'd50, 1'b0); wr(10'h03A, 8'h20, 1'b0);
		CAP.send(8'd52); rd(10'h03D, 32'd52); rd(10'h03C, 32'd13); irq(1'b0);
		CAP.send(8'd53); rd(10'h03D, 32'd53); rd(10'h03C, 32'd13); irq(1'b1);
		wr(10'h042, 8'h02, 1'b0); irq(1'b0);
		wr(10'h03A, 8'h21, 1'b0); CAP.send(8'd50); rd(10'h03C, 32'd13); irq(1'b1);
		wr(10'h03A, 8'h29, 1'b0); CAP.send(8'd50); rd(10'h03C, 32'd22);
		wr(10'h041, 8'h00, 1'b0); irq(1'b0); rd(10'h040, 32'h2);
		wr(10'h041, 8'h03, 1'b0); irq(1'b1); wr(10'h042, 8'h03, 1'b0); irq(1'b0);
		for (j = 0; j < 4; j = j + 1) begin
			wr(10'h043, 8'h01, 1'b0); wr(10'h036, 8'hF8 | (j[7:0] << 1), 1'b0);
			PHS.send(8'h80); rd(10'h038, 32'h20 >> j); rd(10'h039, 32'h80); end
		irq(1'b1);
		wr(10'h043, 8'h01, 1'b0); zeros;
		ceIn <= 1'b0; CAP.send(8'd77); ceIn <= 1'b1;
		rd(10'h03D, 32'h0);
		stop_test;
	end
	initial begin
		#500000;
		n_fail = n_fail + 1;
		stop_test;
	end
endmodule // wakeup_measure_regs_tb
bind wmr_regs wmr_regs_sva #(.DEVICE_TYPE_CODE(DEVICE_TYPE_CODE),
	.SILICON_REVISION_CODE(SILICON_REVISION_CODE), .NUM_CHANNELS(NUM_CHANNELS)) CHK (
	.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .pslverr(pslverr), .wakeIrq(wakeIrq), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .phaseResultValid(phaseResultValid), .capResultValid(capResultValid),
	.phaseResultIn(phaseResultIn), .capResultIn(capResultIn));
